// ---- common/ddt_pkg.sv ----
// constants shared by the descriptor completion and traversal block
// assumes a 32-bit apb register bus with 12-bit byte addresses
package ddt_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int DDT_NSCHED = 3;
  localparam int DDT_NDESC = 32;
  localparam int DDT_AW = 12;
  localparam int DDT_DW = 32;
  localparam int DDT_IW = 5;
  localparam int DDT_LAT_W = 8;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] DDT_IRQ_ENABLE_OFS = 12'h314;
  localparam logic [11:0] DDT_ISO_OR_OFS = 12'h318;
  localparam logic [11:0] DDT_INTERRUPT_LIST_SCHEDULE_OR_OFS = 12'h31c;
  localparam logic [11:0] DDT_ASYNC_OR_OFS = 12'h320;
  localparam logic [11:0] DDT_ISO_AND_OFS = 12'h324;
  localparam logic [11:0] DDT_INTERRUPT_LIST_SCHEDULE_AND_OFS = 12'h328;
  localparam logic [11:0] DDT_ASYNC_AND_OFS = 12'h32c;
  localparam logic [11:0] DDT_CTRL_OFS = 12'h330;
  localparam logic [11:0] DDT_ISO_SKIP_OFS = 12'h334;
  localparam logic [11:0] DDT_INTERRUPT_LIST_SCHEDULE_SKIP_OFS = 12'h338;
  localparam logic [11:0] DDT_ASYNC_SKIP_OFS = 12'h33c;
  localparam logic [11:0] DDT_ISO_DONE_OFS = 12'h340;
  localparam logic [11:0] DDT_INTERRUPT_LIST_SCHEDULE_DONE_OFS = 12'h344;
  localparam logic [11:0] DDT_ASYNC_DONE_OFS = 12'h348;
  localparam logic [11:0] DDT_LAST_OFS = 12'h34c;
  localparam logic [11:0] DDT_STATUS_OFS = 12'h350;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [31:0] DDT_MASK_RST = 32'h0000_0000;
  localparam logic [4:0] DDT_LAST_RST = 5'h1f;
  localparam int DDT_EN_ISO_BIT = 9;
  localparam int DDT_EN_ASYNC_BIT = 8;
  localparam int DDT_EN_INTERRUPT_LIST_SCHEDULE_BIT = 7;
  localparam int DDT_EN_SOF_BIT = 1;
  localparam int DDT_CTRL_LAT_LSB = 8;
  localparam int DDT_LAST_ISO_LSB = 0;
  localparam int DDT_LAST_INTERRUPT_LIST_SCHEDULE_LSB = 8;
  localparam int DDT_LAST_ASYNC_LSB = 16;
  localparam int DDT_STAT_IDX_LSB = 8;
  localparam int DDT_STAT_SCHED_LSB = 4;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int DDT_CLK_PERIOD_NS = 25;
  localparam int DDT_UFRAME_NS = 125000;
  localparam int DDT_UFRAME_CYCLES = DDT_UFRAME_NS / DDT_CLK_PERIOD_NS;

  // ************************************************************
  // schedules and traversal states
  // ************************************************************
  typedef enum logic [1:0] {
    DDT_SCHED_ISO = 2'b00,
    DDT_SCHED_INTERRUPT_LIST_SCHEDULE = 2'b01,
    DDT_SCHED_ASYNC = 2'b10
  } ddt_sched_t;

  typedef enum logic [1:0] {
    DDT_ST_IDLE = 2'b00,
    DDT_ST_FETCH = 2'b01,
    DDT_ST_XACT = 2'b10,
    DDT_ST_STEP = 2'b11
  } ddt_state_t;

endpackage : ddt_pkg

// ---- rtl/ddt_group_eval.sv ----
// completion evaluation of one schedule from its done map and masks
// assumes all inputs are registers on the same clock
`timescale 1ns/100ps
`default_nettype none

module ddt_group_eval #(
  parameter int NDESC = 32
) (
  input wire logic [NDESC-1:0] done_map,
  input wire logic [NDESC-1:0] or_mask,
  input wire logic [NDESC-1:0] and_mask,
  output logic group_done
);

  // ************************************************************
  // or group and and group
  // ************************************************************
  wire logic or_hit;
  wire logic and_hit;

  assign or_hit = |(done_map & or_mask);
  assign and_hit = (|and_mask) && ((done_map & and_mask) == and_mask);
  assign group_done = or_hit | and_hit;

endmodule : ddt_group_eval

`default_nettype wire

// ---- rtl/ddt_done_irq_traversal.sv ----
// descriptor completion grouping, interrupt requests and descriptor walk
// assumes an apb master on pclk, and a descriptor memory and transaction
// engine on the same clock that answer with one-cycle acknowledges
//
// Overview of operation
// - isochronous or-group mask at 0x318, reset zero.
// - interrupt-list or-group mask at 0x31c, reset zero.
// - asynchronous or-group mask at 0x320, read and write.
// - isochronous and-group mask at 0x324, reset zero.
// - interrupt-list and-group mask at 0x328, reset zero.
// - asynchronous and-group mask at 0x32c, reset zero.
// - up to 32 descriptors in each of the three schedules.
// - walk isochronous, then interrupt-list, then asynchronous schedule.
// - evaluate group completion per schedule from masks, signal by interrupt.
// - a descriptor counts done when its done-map bit is set by a completed transaction; a true done flag only skips the transaction.
// - four interrupt sources, latency programmable in 125 us microframes.
// - walk positions upward, honouring skip flags and last position.
// - run a transaction only for active, not yet done descriptors.
// - next position comes from the pointer in word four bits 4..0; used only with the jump flag set, else one position on.
// - jumps only go forward; backward targets are not taken.
// - a skipped descriptor is ignored, the walk goes one position on.
// - a skipped descriptor's jump pointer is disregarded.
// - enable bits 9, 8, 7 gate iso, async, interrupt-list requests.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

module ddt_done_irq_traversal #(
  parameter int UFRAME_CYCLES = ddt_pkg::DDT_UFRAME_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddt_pkg::DDT_AW-1:0] paddr,
  input wire logic [ddt_pkg::DDT_DW-1:0] pwdata,
  output logic [ddt_pkg::DDT_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic desc_rd_req,
  output logic [1:0] desc_sched,
  output logic [ddt_pkg::DDT_IW-1:0] desc_idx,
  input wire logic desc_rd_ack,
  input wire logic desc_jump,
  input wire logic [ddt_pkg::DDT_IW-1:0] desc_next_ptr,
  input wire logic desc_active,
  input wire logic desc_done,
  output logic xact_req,
  input wire logic xact_ack,
  output logic iso_irq,
  output logic interrupt_list_schedule_irq,
  output logic async_irq,
  output logic sof_irq,
  output logic traversal_busy
);
  import ddt_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] or_mask [DDT_NSCHED];
  logic [31:0] and_mask [DDT_NSCHED];
  logic [31:0] skip_map [DDT_NSCHED];
  logic [31:0] done_map [DDT_NSCHED];
  logic [4:0] last_pos [DDT_NSCHED];
  logic [2:0] sched_en;
  logic [DDT_LAT_W-1:0] latency;
  logic [31:0] irq_enable;
  logic [DDT_NSCHED-1:0] irq_q;
  logic [DDT_LAT_W-1:0] lat_cnt [DDT_NSCHED];
  logic [12:0] uf_cnt;
  logic uf_tick;
  ddt_state_t state;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire logic acc;
  wire logic wr;
  wire logic [2:0][11:0] or_ofs;
  wire logic [2:0][11:0] and_ofs;
  wire logic [2:0][11:0] skip_ofs;
  wire logic [2:0][11:0] done_ofs;
  wire logic [2:0] en_bit;
  wire logic wr_ctrl;
  wire logic wr_last;
  wire logic wr_ien;
  wire logic addr_ok;
  wire logic [31:0] rd_mux;
  wire logic [31:0] ctrl_rd;
  wire logic [31:0] last_rd;
  wire logic [31:0] stat_rd;

  assign acc = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite;
  assign or_ofs = {DDT_ASYNC_OR_OFS, DDT_INTERRUPT_LIST_SCHEDULE_OR_OFS, DDT_ISO_OR_OFS};
  assign and_ofs = {DDT_ASYNC_AND_OFS, DDT_INTERRUPT_LIST_SCHEDULE_AND_OFS, DDT_ISO_AND_OFS};
  assign skip_ofs = {DDT_ASYNC_SKIP_OFS, DDT_INTERRUPT_LIST_SCHEDULE_SKIP_OFS, DDT_ISO_SKIP_OFS};
  assign done_ofs = {DDT_ASYNC_DONE_OFS, DDT_INTERRUPT_LIST_SCHEDULE_DONE_OFS, DDT_ISO_DONE_OFS};
  assign en_bit = {irq_enable[DDT_EN_ASYNC_BIT], irq_enable[DDT_EN_INTERRUPT_LIST_SCHEDULE_BIT],
                   irq_enable[DDT_EN_ISO_BIT]};
  assign wr_ctrl = wr && (paddr == DDT_CTRL_OFS);
  assign wr_last = wr && (paddr == DDT_LAST_OFS);
  assign wr_ien = wr && (paddr == DDT_IRQ_ENABLE_OFS);

  assign ctrl_rd = {16'h0000, latency, 5'h00, sched_en};
  assign last_rd = {11'h000, last_pos[2], 3'h0, last_pos[1], 3'h0, last_pos[0]};
  assign stat_rd = {19'h00000, desc_idx, 2'h0, desc_sched, 2'h0, state};

  assign addr_ok = (paddr == DDT_IRQ_ENABLE_OFS) || (paddr == DDT_CTRL_OFS)
                || (paddr == DDT_LAST_OFS) || (paddr == DDT_STATUS_OFS)
                || (paddr == or_ofs[0]) || (paddr == or_ofs[1]) || (paddr == or_ofs[2])
                || (paddr == and_ofs[0]) || (paddr == and_ofs[1]) || (paddr == and_ofs[2])
                || (paddr == skip_ofs[0]) || (paddr == skip_ofs[1]) || (paddr == skip_ofs[2])
                || (paddr == done_ofs[0]) || (paddr == done_ofs[1]) || (paddr == done_ofs[2]);

  assign rd_mux =
      (paddr == DDT_IRQ_ENABLE_OFS) ? irq_enable :
      (paddr == or_ofs[0]) ? or_mask[0] :
      (paddr == or_ofs[1]) ? or_mask[1] :
      (paddr == or_ofs[2]) ? or_mask[2] :
      (paddr == and_ofs[0]) ? and_mask[0] :
      (paddr == and_ofs[1]) ? and_mask[1] :
      (paddr == and_ofs[2]) ? and_mask[2] :
      (paddr == skip_ofs[0]) ? skip_map[0] :
      (paddr == skip_ofs[1]) ? skip_map[1] :
      (paddr == skip_ofs[2]) ? skip_map[2] :
      (paddr == done_ofs[0]) ? done_map[0] :
      (paddr == done_ofs[1]) ? done_map[1] :
      (paddr == done_ofs[2]) ? done_map[2] :
      (paddr == DDT_CTRL_OFS) ? ctrl_rd :
      (paddr == DDT_LAST_OFS) ? last_rd :
      (paddr == DDT_STATUS_OFS) ? stat_rd : 32'h0000_0000;

  // ************************************************************
  // apb answer: one wait state on every access
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_ok;
      end
    end
  end

  // ************************************************************
  // shared control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= 32'h0000_0000;
      sched_en <= 3'h0;
      latency <= '0;
    end else begin
      if (wr_ien) begin
        irq_enable <= pwdata & ((32'h1 << DDT_EN_ISO_BIT) | (32'h1 << DDT_EN_ASYNC_BIT)
                     | (32'h1 << DDT_EN_INTERRUPT_LIST_SCHEDULE_BIT) | (32'h1 << DDT_EN_SOF_BIT));
      end
      if (wr_ctrl) begin
        sched_en <= pwdata[2:0];
        latency <= pwdata[DDT_CTRL_LAT_LSB +: DDT_LAT_W];
      end
    end
  end

  // ************************************************************
  // microframe divider and start-of-frame request
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uf_cnt <= '0;
      uf_tick <= 1'b0;
      sof_irq <= 1'b0;
    end else begin
      uf_tick <= (uf_cnt == 13'(UFRAME_CYCLES - 1));
      uf_cnt <= (uf_cnt == 13'(UFRAME_CYCLES - 1)) ? '0 : uf_cnt + 13'd1;
      sof_irq <= uf_tick & irq_enable[DDT_EN_SOF_BIT];
    end
  end

  // ************************************************************
  // traversal datapath
  // ************************************************************
  wire logic xact_done;
  wire logic [4:0] idx_inc;
  wire logic jump_fwd;
  wire logic [4:0] tgt;
  wire logic cur_skip;
  wire logic end_sched;
  wire logic [1:0] first_sched;
  wire logic [1:0] after_sched;
  wire logic have_after;
  wire logic cur_done;
  logic [4:0] next_idx;

  assign xact_done = xact_req & xact_ack;
  assign idx_inc = desc_idx + 5'd1;
  assign cur_skip = skip_map[desc_sched][desc_idx];
  assign cur_done = desc_done | done_map[desc_sched][desc_idx];
  assign jump_fwd = desc_jump && (desc_next_ptr > desc_idx);
  assign tgt = jump_fwd ? desc_next_ptr : idx_inc;
  assign end_sched = (desc_idx >= last_pos[desc_sched]) || (next_idx <= desc_idx);
  assign first_sched = sched_en[0] ? DDT_SCHED_ISO :
                       sched_en[1] ? DDT_SCHED_INTERRUPT_LIST_SCHEDULE : DDT_SCHED_ASYNC;
  assign after_sched = ((desc_sched == DDT_SCHED_ISO) && sched_en[1]) ?
                       DDT_SCHED_INTERRUPT_LIST_SCHEDULE : DDT_SCHED_ASYNC;
  assign have_after = ((desc_sched == DDT_SCHED_ISO) && (|sched_en[2:1]))
                   || ((desc_sched == DDT_SCHED_INTERRUPT_LIST_SCHEDULE) && sched_en[2]);

  // ************************************************************
  // traversal state machine
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DDT_ST_IDLE;
      desc_sched <= DDT_SCHED_ISO;
      desc_idx <= '0;
      next_idx <= '0;
      desc_rd_req <= 1'b0;
      xact_req <= 1'b0;
      traversal_busy <= 1'b0;
    end else begin
      unique case (state)
        DDT_ST_IDLE: begin
          if (uf_tick && (|sched_en)) begin
            desc_sched <= first_sched;
            desc_idx <= '0;
            traversal_busy <= 1'b1;
            state <= DDT_ST_FETCH;
          end
        end
        DDT_ST_FETCH: begin
          if (cur_skip && !desc_rd_req) begin
            next_idx <= idx_inc;
            state <= DDT_ST_STEP;
          end else if (!desc_rd_req) begin
            desc_rd_req <= 1'b1;
          end else if (desc_rd_ack) begin
            desc_rd_req <= 1'b0;
            next_idx <= tgt;
            if (desc_active && !cur_done) begin
              xact_req <= 1'b1;
              state <= DDT_ST_XACT;
            end else begin
              state <= DDT_ST_STEP;
            end
          end
        end
        DDT_ST_XACT: begin
          if (xact_ack) begin
            xact_req <= 1'b0;
            state <= DDT_ST_STEP;
          end
        end
        DDT_ST_STEP: begin
          if (!end_sched) begin
            desc_idx <= next_idx;
            state <= DDT_ST_FETCH;
          end else if (have_after) begin
            desc_sched <= after_sched;
            desc_idx <= '0;
            state <= DDT_ST_FETCH;
          end else begin
            traversal_busy <= 1'b0;
            state <= DDT_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // per-schedule registers, completion and requests
  // ************************************************************
  genvar s;
  generate
    for (s = 0; s < DDT_NSCHED; s++) begin : g_sched
      wire logic wr_or;
      wire logic wr_and;
      wire logic wr_skip;
      wire logic wr_done;
      wire logic [31:0] set_vec;
      wire logic [31:0] clr_vec;
      wire logic grp_done;
      wire logic lat_ok;

      assign wr_or = wr && (paddr == or_ofs[s]);
      assign wr_and = wr && (paddr == and_ofs[s]);
      assign wr_skip = wr && (paddr == skip_ofs[s]);
      assign wr_done = wr && (paddr == done_ofs[s]);
      assign set_vec = (xact_done && (desc_sched == 2'(s))) ? (32'h1 << desc_idx) : 32'h0;
      assign clr_vec = wr_done ? pwdata : 32'h0;
      assign lat_ok = (lat_cnt[s] >= latency);

      ddt_group_eval #(
        .NDESC(DDT_NDESC)
      ) u_eval (
        .done_map(done_map[s]),
        .or_mask(or_mask[s]),
        .and_mask(and_mask[s]),
        .group_done(grp_done)
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          or_mask[s] <= DDT_MASK_RST;
          and_mask[s] <= DDT_MASK_RST;
          skip_map[s] <= DDT_MASK_RST;
          done_map[s] <= DDT_MASK_RST;
          last_pos[s] <= DDT_LAST_RST;
          lat_cnt[s] <= '0;
          irq_q[s] <= 1'b0;
        end else begin
          if (wr_or) begin
            or_mask[s] <= pwdata;
          end
          if (wr_and) begin
            and_mask[s] <= pwdata;
          end
          if (wr_skip) begin
            skip_map[s] <= pwdata;
          end
          if (wr_last) begin
            last_pos[s] <= pwdata[8*s +: 5];
          end
          // a completion in the clearing cycle survives the clear
          done_map[s] <= (done_map[s] & ~clr_vec) | set_vec;
          if (!grp_done) begin
            lat_cnt[s] <= '0;
          end else if (uf_tick && !lat_ok) begin
            lat_cnt[s] <= lat_cnt[s] + DDT_LAT_W'(1);
          end
          irq_q[s] <= en_bit[s] & grp_done & lat_ok;
        end
      end
    end
  endgenerate

  assign iso_irq = irq_q[0];
  assign interrupt_list_schedule_irq = irq_q[1];
  assign async_irq = irq_q[2];

endmodule : ddt_done_irq_traversal

`default_nettype wire

// ---- sim/ddt_done_irq_traversal_checker.sv ----
// concurrent checks on the ports of the descriptor walk block
// assumes the single pclk domain; bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module ddt_chk import ddt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ddt_pkg::DDT_AW-1:0] paddr,
  input wire logic [ddt_pkg::DDT_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic desc_rd_req,
  input wire logic [1:0] desc_sched,
  input wire logic [ddt_pkg::DDT_IW-1:0] desc_idx,
  input wire logic desc_rd_ack,
  input wire logic desc_jump,
  input wire logic [ddt_pkg::DDT_IW-1:0] desc_next_ptr,
  input wire logic desc_active,
  input wire logic desc_done,
  input wire logic xact_req,
  input wire logic xact_ack,
  input wire logic sof_irq,
  input wire logic traversal_busy
);
  // *****
  // helpers: decoded map and pending forward jump
  // *****
  wire logic mapped = (paddr[1:0] == 2'b00) && (paddr >= DDT_IRQ_ENABLE_OFS) && (paddr <= DDT_STATUS_OFS);
  logic pend;
  logic [4:0] tgt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
      tgt <= 5'h00;
    end else if (desc_rd_ack && desc_jump && (desc_next_ptr > desc_idx)) begin
      pend <= 1'b1;
      tgt <= desc_next_ptr;
    end else if (desc_rd_req) begin
      pend <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access_wait;
    psel && penable && !pready;
  endsequence
  sequence s_jump_fetch;
    pend && desc_rd_req;
  endsequence
  chk_ready_wait: assert property (s_access_wait |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_slverr_map: assert property (pready |-> (pslverr == !mapped)) else $error("pslverr wrong");
  chk_unmapped_zero: assert property (pready && !pwrite && !mapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rdreq_hold: assert property (desc_rd_req && !desc_rd_ack |=> desc_rd_req && $stable(desc_idx))
    else $error("descriptor read dropped");
  chk_xact_hold: assert property (xact_req && !xact_ack |=> xact_req)
    else $error("transaction dropped");
  chk_no_idle_xact: assert property (desc_rd_ack && !(desc_active && !desc_done) |=> !xact_req)
    else $error("transaction on idle descriptor");
  chk_sched_order: assert property (traversal_busy && $past(traversal_busy)
    |-> desc_sched >= $past(desc_sched)) else $error("schedule order");
  chk_jump_target: assert property (s_jump_fetch |-> desc_idx == tgt)
    else $error("jump target missed");
  chk_jump_bound: assert property (pend |-> ##[0:60] !pend)
    else $error("jump fetch never came");
  chk_sof_pulse: assert property (sof_irq |=> !sof_irq [*8])
    else $error("frame pulse too dense");
endmodule : ddt_chk

bind ddt_done_irq_traversal ddt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .desc_rd_req(desc_rd_req), .desc_sched(desc_sched), .desc_idx(desc_idx), .desc_rd_ack(desc_rd_ack),
  .desc_jump(desc_jump), .desc_next_ptr(desc_next_ptr), .desc_active(desc_active), .desc_done(desc_done),
  .xact_req(xact_req), .xact_ack(xact_ack), .sof_irq(sof_irq), .traversal_busy(traversal_busy));
`default_nettype wire

// ---- sim/ddt_mem_model.sv ----
// descriptor memory and transaction engine seen from the walk block
// assumes the bench fills cfg after reset; read answers alternate prompt and slow, transaction answers after the first wait 2 cycles
`timescale 1ns/100ps
`default_nettype none
module ddt_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic desc_rd_req,
  input wire logic [1:0] desc_sched,
  input wire logic [4:0] desc_idx,
  output logic desc_rd_ack,
  output logic desc_jump,
  output logic [4:0] desc_next_ptr,
  output logic desc_active,
  output logic desc_done,
  input wire logic xact_req,
  output logic xact_ack
);
  // *****
  // word four image per position: done, active, jump, pointer
  // *****
  logic [7:0] cfg [96];
  logic [6:0] vis_q [$];
  logic [6:0] xq [$];
  int rc;
  int xc;
  initial foreach (cfg[i]) cfg[i] = 8'h00;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_rd_ack <= 1'b0;
      xact_ack <= 1'b0;
      {desc_done, desc_active, desc_jump, desc_next_ptr} <= 8'h00;
      rc <= 0;
      xc <= 0;
    end else begin
      desc_rd_ack <= 1'b0;
      xact_ack <= 1'b0;
      if (desc_rd_req && !desc_rd_ack && rc == 0) begin
        desc_rd_ack <= 1'b1;
        {desc_done, desc_active, desc_jump, desc_next_ptr} <= cfg[int'(desc_sched) * 32 + int'(desc_idx)];
        vis_q.push_back({desc_sched, desc_idx});
        rc <= (vis_q.size() % 2) * 3;
      end else begin
        // word is not valid outside the ack cycle, so it keeps changing
        {desc_done, desc_active, desc_jump, desc_next_ptr} <= ~{desc_done, desc_active, desc_jump, desc_next_ptr};
        if (desc_rd_req && rc > 0) rc <= rc - 1;
      end
      if (xact_req && !xact_ack && xc == 0) begin
        xact_ack <= 1'b1;
        xq.push_back({desc_sched, desc_idx});
        xc <= 2;
      end else if (xact_req && xc > 0) begin
        xc <= xc - 1;
      end
    end
  end
endmodule : ddt_mem_model
`default_nettype wire

// ---- sim/ddt_done_irq_traversal_tb.sv ----
// apb driven bench for descriptor grouping and walk
// assumes the memory model answers the walk; frame tick shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module ddt_done_irq_traversal_tb;
  import ddt_pkg::*;
  // *****
  // signals and instances
  // *****
  localparam int UF = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, desc_rd_req, desc_rd_ack, desc_jump, desc_active, desc_done;
  logic xact_req, xact_ack, iso_irq, interrupt_list_schedule_irq, async_irq, sof_irq, traversal_busy, seen;
  logic [1:0] desc_sched;
  logic [4:0] desc_idx, desc_next_ptr;
  int n_errors = 0;
  int comparisons = 0;
  logic [11:0] mofs [6] = '{DDT_ISO_OR_OFS, DDT_INTERRUPT_LIST_SCHEDULE_OR_OFS, DDT_ASYNC_OR_OFS,
    DDT_ISO_AND_OFS, DDT_INTERRUPT_LIST_SCHEDULE_AND_OFS, DDT_ASYNC_AND_OFS};
  logic [6:0] exp_v [6] = '{7'h00, 7'h02, 7'h04, 7'h20, 7'h21, 7'h40};
  logic [6:0] exp_x [4] = '{7'h00, 7'h02, 7'h04, 7'h21};
  always #12.5 pclk = ~pclk;
  ddt_done_irq_traversal #(.UFRAME_CYCLES(UF)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .desc_rd_req(desc_rd_req), .desc_sched(desc_sched), .desc_idx(desc_idx),
    .desc_rd_ack(desc_rd_ack), .desc_jump(desc_jump), .desc_next_ptr(desc_next_ptr), .desc_active(desc_active),
    .desc_done(desc_done), .xact_req(xact_req), .xact_ack(xact_ack), .iso_irq(iso_irq), .interrupt_list_schedule_irq(interrupt_list_schedule_irq),
    .async_irq(async_irq), .sof_irq(sof_irq), .traversal_busy(traversal_busy));
  ddt_mem_model u_mem (.pclk(pclk), .presetn(presetn), .desc_rd_req(desc_rd_req), .desc_sched(desc_sched),
    .desc_idx(desc_idx), .desc_rd_ack(desc_rd_ack), .desc_jump(desc_jump), .desc_next_ptr(desc_next_ptr),
    .desc_active(desc_active), .desc_done(desc_done), .xact_req(xact_req), .xact_ack(xact_ack));
  // *****
  // tasks
  // *****
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
  // *****
  // tests
  // *****
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, DDT_LAST_OFS, 0);
    chk("last positions", 32'h001f_1f1f, rd);
    for (int i = 0; i < 6; i++) begin
      apb(0, mofs[i], 0);
      chk("mask reset", 32'h0000_0000, rd);
      apb(1, mofs[i], 32'h5a5a_a5a5 ^ i);
      apb(0, mofs[i], 0);
      chk("mask rw", 32'h5a5a_a5a5 ^ i, rd);
      apb(1, mofs[i], 0);
    end
    apb(0, 12'h400, 0);
    chk("unmapped read", 32'h0000_0001, {rd[31:1], er});
    $display("test registers done");
    // software keeps iso jumps forward, at most to last, never onto skipped positions; the list jump at 0 points back to 0
    u_mem.cfg[0] = 8'h40;
    u_mem.cfg[1] = 8'h64;
    u_mem.cfg[2] = 8'h64;
    u_mem.cfg[3] = 8'h40;
    u_mem.cfg[4] = 8'h40;
    u_mem.cfg[32] = 8'h20;
    u_mem.cfg[33] = 8'h40;
    u_mem.cfg[64] = 8'hc0;
    apb(1, DDT_ISO_SKIP_OFS, 32'h0000_0002);
    apb(1, DDT_LAST_OFS, 32'h0000_0104);
    apb(1, DDT_CTRL_OFS, 32'h0000_0007);
    while (traversal_busy !== 1'b1) @(posedge pclk);
    while (traversal_busy === 1'b1) @(posedge pclk);
    apb(1, DDT_CTRL_OFS, 0);
    @(posedge pclk);
    while (traversal_busy === 1'b1) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      chk("visit", {25'h0, exp_v[i]}, {25'h0, u_mem.vis_q[i]});
    end
    chk("xact count", 4, u_mem.xq.size());
    for (int i = 0; i < 4; i++) chk("xact", {25'h0, exp_x[i]}, {25'h0, u_mem.xq[i]});
    apb(0, DDT_ISO_DONE_OFS, 0);
    chk("iso done map", 32'h0000_0015, rd);
    apb(0, DDT_INTERRUPT_LIST_SCHEDULE_DONE_OFS, 0);
    chk("list done map", 32'h0000_0002, rd);
    $display("test walk done");
    apb(1, DDT_IRQ_ENABLE_OFS, 32'h0000_0382);
    repeat (2) @(posedge pclk);
    chk("iso irq empty masks", 0, iso_irq);
    apb(1, DDT_ISO_OR_OFS, 32'h0000_0001);
    apb(1, DDT_INTERRUPT_LIST_SCHEDULE_AND_OFS, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk("iso irq or", 1, iso_irq);
    chk("list irq and partial", 0, interrupt_list_schedule_irq);
    chk("async irq", 0, async_irq);
    apb(1, DDT_INTERRUPT_LIST_SCHEDULE_AND_OFS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("list irq and full", 1, interrupt_list_schedule_irq);
    apb(1, DDT_IRQ_ENABLE_OFS, 32'h0000_0082);
    repeat (2) @(posedge pclk);
    chk("iso irq gated", 0, iso_irq);
    chk("list irq kept", 1, interrupt_list_schedule_irq);
    seen = 1'b0;
    repeat (UF + 5) @(posedge pclk) if (sof_irq === 1'b1) seen = 1'b1;
    chk("frame pulse", 1, seen);
    apb(1, DDT_INTERRUPT_LIST_SCHEDULE_DONE_OFS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("list irq cleared", 0, interrupt_list_schedule_irq);
    apb(1, DDT_IRQ_ENABLE_OFS, 32'hffff_ffff);
    apb(0, DDT_IRQ_ENABLE_OFS, 0);
    chk("enable reserved", 32'h0000_0382, rd);
    apb(1, DDT_CTRL_OFS, 32'h0000_0200);
    repeat (2) @(posedge pclk);
    chk("iso irq latency wait", 0, iso_irq);
    repeat (2 * UF + 5) @(posedge pclk);
    chk("iso irq latency", 1, iso_irq);
    $display("test interrupts done");
    end_sim();
  end
endmodule : ddt_done_irq_traversal_tb
`default_nettype wire
